// file: inc/pmc_regs.vh
// Register offsets, field positions, reset values and timing counts for the CRC launch block
`ifndef PMC_REGS_VH
`define PMC_REGS_VH

// Link register addresses (8-bit)
`define PMC_ADDR_STATUS    8'hA7
`define PMC_ADDR_CRC_B0    8'hA9
`define PMC_ADDR_CRC_B1    8'hAA
`define PMC_ADDR_CRC_B2    8'hAB
`define PMC_ADDR_CRC_B3    8'hAC

// Status field and reset values
`define PMC_STATUS_BUSY_BIT 0
`define PMC_BYTE_RESET      8'h00
`define PMC_UNMAPPED_READ   8'h00

// Program memory geometry
`define PMC_MEM_AW          14
`define PMC_MEM_DEPTH       16384
`define PMC_MEM_START       14'h0000
`define PMC_BLOCK_LOW       8'h00
`define PMC_BLOCK_LAST      8'hFF

// CRC polynomials and seeds, MSB-first
`define PMC_CRC32_POLY      32'h04C11DB7
`define PMC_CRC32_INIT      32'hFFFFFFFF
`define PMC_CRC16_POLY      16'h1021
`define PMC_CRC16_INIT      16'hFFFF

// Link framing: bits per frame part
`define PMC_CNT_ADDR_DONE   5'd9
`define PMC_CNT_FRAME_DONE  5'd17

// Frame resync when the link clock idles high this long
`define PMC_CLK_NS          25
`define PMC_IDLE_NS         1000
// Idle count in system clocks: 1000 ns at 25 ns, sized for the 7-bit idle counter
`define PMC_IDLE_CYC        7'd40

`endif

// file: hw/pmc_rom.v
// Program memory array with one registered read port and one write port
`include "pmc_regs.vh"

module pmc_rom (
  input  wire                    clk_i,
  input  wire                    wr_en_i,
  input  wire [`PMC_MEM_AW-1:0]  wr_addr_i,
  input  wire [7:0]              wr_data_i,
  input  wire [`PMC_MEM_AW-1:0]  rd_addr_i,
  output reg  [7:0]              rd_data_o
);

  reg [7:0] mem [0:`PMC_MEM_DEPTH-1];

  // Read data is registered so the array maps onto block memory
  always @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end

endmodule

// file: hw/pmc_top.v
// Debug-link register slave that launches program memory CRCs and reports results
//
// Behaviour
// - A write to the second checksum byte while no CRC runs starts a 32-bit CRC over all memory.
// - The full-memory CRC starts reading at address zero and walks every byte.
// - Result bytes: for the 32-bit CRC fourth holds MSB, first holds LSB, second and third in order; the 16-bit CRC puts MSB in second, LSB in first.
// - Link traffic is meant for the halted state, with core and peripherals stalled.
// - While halted, reset pin becomes link clock and shared pin becomes link data.
// - Write to first byte starts 16-bit CRC over 256 bytes, upper address byte written.
`include "pmc_regs.vh"

module pmc_top (
  input  wire                   clk_i,
  input  wire                   reset_i,
  input  wire                   halted_i,
  input  wire                   debug_link_clock_pin_i,
  input  wire                   debug_link_data_pin_i,
  output reg                    debug_link_data_pin_o,
  output reg                    debug_link_data_pin_oe_o,
  input  wire                   user_data_out_i,
  input  wire                   user_data_oe_i,
  output wire                   user_data_in_o,
  output reg                    core_reset_o,
  input  wire                   mem_wr_en_i,
  input  wire [`PMC_MEM_AW-1:0] mem_wr_addr_i,
  input  wire [7:0]             mem_wr_data_i,
  output wire                   crc_busy_o
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_READ = 3'b010;
  localparam [2:0] ST_ACC  = 3'b100;
  localparam [6:0] IDLE_CYC = `PMC_IDLE_CYC;

  ////////////////////////////////////////////////////////////////////////////////
  // CRC step functions, one byte per call, MSB first
  function [31:0] crc32_byte;
    input [31:0] crc;
    input [7:0]  data;
    integer      i;
    reg   [31:0] c;
    begin
      c = crc ^ {data, 24'h000000};
      for (i = 0; i < 8; i = i + 1) begin
        c = c[31] ? ({c[30:0], 1'b0} ^ `PMC_CRC32_POLY) : {c[30:0], 1'b0};
      end
      crc32_byte = c;
    end
  endfunction

  function [15:0] crc16_byte;
    input [15:0] crc;
    input [7:0]  data;
    integer      i;
    reg   [15:0] c;
    begin
      c = crc ^ {data, 8'h00};
      for (i = 0; i < 8; i = i + 1) begin
        c = c[15] ? ({c[14:0], 1'b0} ^ `PMC_CRC16_POLY) : {c[14:0], 1'b0};
      end
      crc16_byte = c;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second; core reset rides along
  reg clk_s1_q;
  reg clk_s2_q;
  reg clk_s3_q;
  reg dat_s1_q;
  reg dat_s2_q;

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      clk_s1_q <= 1'b1;
      clk_s2_q <= 1'b1;
      clk_s3_q <= 1'b1;
      dat_s1_q <= 1'b0;
      dat_s2_q <= 1'b0;
      core_reset_o <= 1'b1;
    end else begin
      clk_s1_q <= debug_link_clock_pin_i;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
      dat_s1_q <= debug_link_data_pin_i;
      dat_s2_q <= dat_s1_q;
      // Reset pin is the core reset when running, the link clock when halted
      core_reset_o <= ~halted_i & ~clk_s2_q;
    end
  end

  wire link_rise = clk_s2_q & ~clk_s3_q;
  wire link_fall = ~clk_s2_q & clk_s3_q;

  // Shared pin goes to user logic only outside the halted state
  assign user_data_in_o = halted_i ? 1'b0 : dat_s2_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Link frame receiver: rw bit, 8 address bits, then 8 data bits either way

  reg [4:0] bit_cnt_q;
  reg [6:0] idle_cnt_q;
  reg       rw_q;
  reg [7:0] addr_q;
  reg [7:0] wdata_q;
  reg [7:0] rshift_q;
  reg       drive_q;
  reg       wr_stb_q;
  reg [7:0] rd_val;

  wire in_data = (bit_cnt_q >= `PMC_CNT_ADDR_DONE) && (bit_cnt_q < `PMC_CNT_FRAME_DONE);

  // Idle high clock for a while resynchronises framing; link works only halted
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      bit_cnt_q  <= 5'd0;
      idle_cnt_q <= 7'd0;
      rw_q       <= 1'b0;
      addr_q     <= 8'h00;
      wdata_q    <= 8'h00;
      rshift_q   <= 8'h00;
      drive_q    <= 1'b0;
      wr_stb_q   <= 1'b0;
    end else begin
      wr_stb_q <= 1'b0;
      if (!halted_i) begin
        bit_cnt_q  <= 5'd0;
        idle_cnt_q <= 7'd0;
        drive_q    <= 1'b0;
      end else if (clk_s2_q && idle_cnt_q >= IDLE_CYC) begin
        bit_cnt_q <= 5'd0;
        drive_q   <= 1'b0;
      end else begin
        idle_cnt_q <= clk_s2_q ? idle_cnt_q + 7'd1 : 7'd0;
        if (link_rise) begin
          idle_cnt_q <= 7'd0;
          if (bit_cnt_q == 5'd0) begin
            rw_q <= dat_s2_q;
          end else if (bit_cnt_q < `PMC_CNT_ADDR_DONE) begin
            addr_q <= {addr_q[6:0], dat_s2_q};
          end else begin
            wdata_q <= {wdata_q[6:0], dat_s2_q};
          end
          if (bit_cnt_q == `PMC_CNT_ADDR_DONE - 5'd1) begin
            rshift_q <= rd_val;
          end
          if (bit_cnt_q == `PMC_CNT_FRAME_DONE - 5'd1) begin
            wr_stb_q <= rw_q;
            drive_q  <= 1'b0;
            bit_cnt_q <= 5'd0;
          end else begin
            bit_cnt_q <= bit_cnt_q + 5'd1;
          end
        end else if (link_fall && in_data && !rw_q) begin
          drive_q  <= 1'b1;
          rshift_q <= {rshift_q[6:0], 1'b0};
        end
      end
    end
  end

  // Read value is looked up from the address being completed this edge
  wire [7:0] addr_next = {addr_q[6:0], dat_s2_q};

  ////////////////////////////////////////////////////////////////////////////////
  // Data pin driver, registered; bits change on falling link clock edges
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      debug_link_data_pin_o    <= 1'b0;
      debug_link_data_pin_oe_o <= 1'b0;
    end else if (halted_i) begin
      debug_link_data_pin_o    <= (link_fall && in_data && !rw_q) ? rshift_q[7]
                                                                  : debug_link_data_pin_o;
      debug_link_data_pin_oe_o <= drive_q | (link_fall && in_data && !rw_q);
    end else begin
      debug_link_data_pin_o    <= user_data_out_i;
      debug_link_data_pin_oe_o <= user_data_oe_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // CRC engine
  reg [2:0]             state_q;
  reg                   full_q;
  reg [`PMC_MEM_AW-1:0] rd_addr_q;
  reg [31:0]            crc32_q;
  reg [15:0]            crc16_q;
  reg [7:0]             byte0_q;
  reg [7:0]             byte1_q;
  reg [7:0]             byte2_q;
  reg [7:0]             byte3_q;
  wire [7:0]            mem_data;

  wire busy = (state_q != ST_IDLE);
  assign crc_busy_o = busy;

  wire last_byte = full_q ? (rd_addr_q == {`PMC_MEM_AW{1'b1}})
                          : (rd_addr_q[7:0] == `PMC_BLOCK_LAST);

  wire [31:0] crc32_nx = crc32_byte(crc32_q, mem_data);
  wire [15:0] crc16_nx = crc16_byte(crc16_q, mem_data);

  // Launch writes are ignored while a CRC is running
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q   <= ST_IDLE;
      full_q    <= 1'b0;
      rd_addr_q <= `PMC_MEM_START;
      crc32_q   <= `PMC_CRC32_INIT;
      crc16_q   <= `PMC_CRC16_INIT;
      byte0_q   <= `PMC_BYTE_RESET;
      byte1_q   <= `PMC_BYTE_RESET;
      byte2_q   <= `PMC_BYTE_RESET;
      byte3_q   <= `PMC_BYTE_RESET;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (wr_stb_q) begin
            if (addr_q == `PMC_ADDR_CRC_B1) begin
              byte1_q   <= wdata_q;
              full_q    <= 1'b1;
              rd_addr_q <= `PMC_MEM_START;
              crc32_q   <= `PMC_CRC32_INIT;
              state_q   <= ST_READ;
            end else if (addr_q == `PMC_ADDR_CRC_B0) begin
              byte0_q   <= wdata_q;
              full_q    <= 1'b0;
              rd_addr_q <= {wdata_q[`PMC_MEM_AW-9:0], `PMC_BLOCK_LOW};
              crc16_q   <= `PMC_CRC16_INIT;
              state_q   <= ST_READ;
            end else if (addr_q == `PMC_ADDR_CRC_B2) begin
              byte2_q <= wdata_q;
            end else if (addr_q == `PMC_ADDR_CRC_B3) begin
              byte3_q <= wdata_q;
            end
          end
        end
        ST_READ: begin
          state_q <= ST_ACC; // Memory data is valid one cycle later
        end
        ST_ACC: begin
          crc32_q <= crc32_nx;
          crc16_q <= crc16_nx;
          if (last_byte) begin
            state_q <= ST_IDLE;
            if (full_q) begin
              byte3_q <= crc32_nx[31:24];
              byte2_q <= crc32_nx[23:16];
              byte1_q <= crc32_nx[15:8];
              byte0_q <= crc32_nx[7:0];
            end else begin
              byte1_q <= crc16_nx[15:8];
              byte0_q <= crc16_nx[7:0];
            end
          end else begin
            rd_addr_q <= rd_addr_q + 1'b1;
            state_q   <= ST_READ;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  pmc_rom u_rom (
    .clk_i     (clk_i),
    .wr_en_i   (mem_wr_en_i),
    .wr_addr_i (mem_wr_addr_i),
    .wr_data_i (mem_wr_data_i),
    .rd_addr_i (rd_addr_q),
    .rd_data_o (mem_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Register read decode; partial results are hidden while busy
  always @* begin
    rd_val = `PMC_UNMAPPED_READ;
    if (addr_next == `PMC_ADDR_STATUS) begin
      rd_val = 8'h00;
      rd_val[`PMC_STATUS_BUSY_BIT] = busy;
    end else if (busy) begin
      rd_val = `PMC_UNMAPPED_READ;
    end else if (addr_next == `PMC_ADDR_CRC_B0) begin
      rd_val = byte0_q;
    end else if (addr_next == `PMC_ADDR_CRC_B1) begin
      rd_val = byte1_q;
    end else if (addr_next == `PMC_ADDR_CRC_B2) begin
      rd_val = byte2_q;
    end else if (addr_next == `PMC_ADDR_CRC_B3) begin
      rd_val = byte3_q;
    end
  end

endmodule

// file: dv/pmc_top_sva.sv
// Port checker for the CRC launch block
module pmc_top_sva (
  input logic clk_i,
  input logic reset_i,
  input logic halted_i,
  input logic debug_link_clock_pin_i,
  input logic debug_link_data_pin_i,
  input logic debug_link_data_pin_oe_o,
  input logic user_data_in_o,
  input logic user_data_oe_i,
  input logic core_reset_o,
  input logic crc_busy_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic [15:0] run_q;
  ////////////////////////////////////////
  // Busy run length; 16 bits cover a full pass with margin
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i)
      run_q <= 16'h0000;
    else
      run_q <= crc_busy_o ? run_q + 16'h0001 : 16'h0000;
  end
  // Link clock parked high while halted, longer than any frame half
  sequence ck_high_s;
    (halted_i && debug_link_clock_pin_i) [*7];
  endsequence
  // Reset pin held low while the core runs
  sequence pin_low_s;
    (!halted_i && !debug_link_clock_pin_i) [*5];
  endsequence
  busy_min_a: assert property ($fell(crc_busy_o) |-> $past(run_q) >= 16'h0100)
    else $error("CRC run shorter than one block");
  busy_max_a: assert property (run_q <= 16'h8100)
    else $error("CRC busy never ends");
  busy_halt_a: assert property ($rose(crc_busy_o) |-> halted_i)
    else $error("CRC started while core runs");
  // Outside a halt the shared pin enable is the user's, one register late
  oe_user_a: assert property (!$past(halted_i) |->
    debug_link_data_pin_oe_o == $past(user_data_oe_i))
    else $error("Data pin enable not taken from user logic");
  oe_idle_a: assert property (ck_high_s |-> !debug_link_data_pin_oe_o)
    else $error("Data pin driven outside a frame");
  oe_rise_a: assert property (ck_high_s |=> !$rose(debug_link_data_pin_oe_o))
    else $error("Data pin drive began without a falling edge");
  user_mute_a: assert property (halted_i && $past(halted_i) |-> !user_data_in_o)
    else $error("Shared pin leaked to user logic");
  user_pass_a: assert property ((!halted_i && $stable(debug_link_data_pin_i)) [*4] |->
    user_data_in_o == debug_link_data_pin_i)
    else $error("Shared pin not passed to user logic");
  core_rst_a: assert property (pin_low_s |-> core_reset_o)
    else $error("Core reset missing");
  core_run_a: assert property ((halted_i || debug_link_clock_pin_i) [*5] |-> !core_reset_o)
    else $error("Core reset while pin high or halted");
endmodule

bind pmc_top pmc_top_sva u_sva (.clk_i(clk_i), .reset_i(reset_i), .halted_i(halted_i),
  .debug_link_clock_pin_i(debug_link_clock_pin_i), .debug_link_data_pin_i(debug_link_data_pin_i),
  .debug_link_data_pin_oe_o(debug_link_data_pin_oe_o), .user_data_in_o(user_data_in_o),
  .core_reset_o(core_reset_o), .crc_busy_o(crc_busy_o), .user_data_oe_i(user_data_oe_i));

// file: dv/pmc_link_host.sv
// Debug adapter model driving the two-wire link
module pmc_link_host (
  input  logic       clk_i,
  input  logic       data_i,
  output logic       ck_o,
  output logic       d_o,
  output logic       oe_o,
  output logic       rd_valid_o,
  output logic [7:0] rd_data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Clock parks high between frames
  initial begin
    ck_o = 1'b1;
    d_o = 1'b0;
    oe_o = 1'b0;
    rd_valid_o = 1'b0;
    rd_data_o = 8'h00;
  end
  ////////////////////////////////////////
  // Outside a halt the pin is a plain reset input
  task automatic set_ck(input logic v);
    ck_o = v;
  endtask
  // One frame of 17 bits at 200 ns; bits change while the clock is low
  task automatic frame(input logic wr, input logic [7:0] a, input logic [7:0] w);
    logic [16:0] b;
    b = {wr, a, w};
    #7;
    oe_o = 1'b1;
    for (int i = 0; i < 17; i++) begin
      ck_o = 1'b0;
      if (i > 8 && !wr)
        oe_o = 1'b0;
      #50;
      d_o = b[16 - i];
      #50;
      if (i > 8 && !wr)
        rd_data_o = {rd_data_o[6:0], data_i};
      ck_o = 1'b1;
      #100;
    end
    oe_o = 1'b0;
    #400;
    if (!wr) begin
      @(posedge clk_i);
      rd_valid_o <= 1'b1;
      @(posedge clk_i);
      rd_valid_o <= 1'b0;
    end
  endtask
endmodule

// file: dv/testbench.sv
// Self-checking bench for the CRC launch block
`include "pmc_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic                   clk_i = 1'b0;
  logic                   reset_i = 1'b1;
  logic                   halted_i = 1'b0;
  logic                   u_d = 1'b0;
  logic                   u_oe = 1'b0;
  logic                   tgl_q = 1'b0;
  logic                   mem_we = 1'b0;
  logic [`PMC_MEM_AW-1:0] mem_a = '0;
  logic [7:0]             mem_d = 8'h00;
  logic [7:0]             mem_q [0:`PMC_MEM_DEPTH-1];
  logic [7:0]             blk;
  logic [31:0]            e;
  logic [15:0]            exp_q [$];
  int                     fails = 0;
  int                     cmp_count = 0;
  int                     cyc = 0;
  wire                    ck, hd, hoe, rdv, dout, doe, uin, crst, busy;
  wire [7:0]              rdd;
  // Released pin shows a toggling pattern, never the last value
  wire                    pin = doe ? dout : hoe ? hd : u_oe ? u_d : tgl_q;

  pmc_top uut (.clk_i(clk_i), .reset_i(reset_i), .halted_i(halted_i),
    .debug_link_clock_pin_i(ck), .debug_link_data_pin_i(pin), .debug_link_data_pin_o(dout),
    .debug_link_data_pin_oe_o(doe), .user_data_out_i(u_d), .user_data_oe_i(u_oe),
    .user_data_in_o(uin), .core_reset_o(crst), .mem_wr_en_i(mem_we), .mem_wr_addr_i(mem_a),
    .mem_wr_data_i(mem_d), .crc_busy_o(busy));
  pmc_link_host host (.clk_i(clk_i), .data_i(pin), .ck_o(ck), .d_o(hd), .oe_o(hoe),
    .rd_valid_o(rdv), .rd_data_o(rdd));

  // Clock, release pattern and hang guard
  initial forever #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    tgl_q <= ~tgl_q;
    cyc++;
    if (cyc == 80000) begin
      fails++;
      $display("ERROR %0t run timed out", $time);
      report_and_stop();
    end
  end
  // Oldest note {mask, value} is matched against each finished read
  always @(posedge clk_i) begin
    if (rdv === 1'b1) begin
      cmp_count++;
      if (exp_q.size() == 0 || (rdd & exp_q[0][15:8]) !== exp_q[0][7:0]) begin
        fails++;
        $display("ERROR %0t read data mismatch", $time);
      end
      if (exp_q.size() != 0)
        void'(exp_q.pop_front());
    end
  end
  ////////////////////////////////////////
  task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m = 8'hFF);
    exp_q.push_back({m, x & m});
    host.frame(1'b0, a, 8'h00);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    host.frame(1'b1, a, w);
  endtask
  task automatic chk(input logic ok);
    cmp_count++;
    if (ok !== 1'b1) begin
      fails++;
      $display("ERROR %0t port level wrong", $time);
    end
  endtask
  task automatic wait_idle();
    for (int n = 0; n < 40000 && busy !== 1'b0; n++)
      @(posedge clk_i);
    if (busy !== 1'b0) begin
      fails++;
      $display("ERROR %0t CRC never finished", $time);
    end
  endtask
  // MSB-first CRC of width w over n preloaded bytes from base
  function automatic logic [31:0] crc_calc(input int w, input int base, input int n);
    logic [31:0] c;
    logic [31:0] p;
    logic [31:0] k;
    c = (w == 32) ? `PMC_CRC32_INIT : {16'h0000, `PMC_CRC16_INIT};
    p = (w == 32) ? `PMC_CRC32_POLY : {16'h0000, `PMC_CRC16_POLY};
    k = (w == 32) ? 32'hFFFFFFFF : 32'h0000FFFF;
    for (int a = base; a < base + n; a++)
      for (int b = 7; b >= 0; b--)
        c = ((c << 1) ^ ((c[w-1] ^ mem_q[a][b]) ? p : 32'h00000000)) & k;
    return c;
  endfunction
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    void'($urandom(32'h0605e424));
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    for (int a = 0; a < `PMC_MEM_DEPTH; a++) begin
      mem_q[a] = 8'($urandom);
      mem_we <= 1'b1;
      mem_a <= a[`PMC_MEM_AW-1:0];
      mem_d <= mem_q[a];
      @(posedge clk_i);
    end
    mem_we <= 1'b0;
    halted_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    for (int i = 0; i < 4; i++)
      rd(`PMC_ADDR_CRC_B0 + 8'(i), `PMC_BYTE_RESET);
    rd(8'h55, `PMC_UNMAPPED_READ);
    $display("Test reset values done");
    blk = 8'($urandom);
    wr(`PMC_ADDR_CRC_B0, blk);
    wait_idle();
    e = crc_calc(16, {blk[5:0], 8'h00}, 256);
    rd(`PMC_ADDR_CRC_B1, e[15:8]);
    rd(`PMC_ADDR_CRC_B0, e[7:0]);
    $display("Test block CRC done");
    // A nonzero stored byte makes the hold-off read below able to fail
    wr(`PMC_ADDR_CRC_B3, 8'hA5);
    rd(`PMC_ADDR_CRC_B3, 8'hA5);
    wr(`PMC_ADDR_CRC_B1, 8'($urandom));
    chk(busy === 1'b1);
    rd(`PMC_ADDR_STATUS, 8'h01, 8'h01);
    rd(`PMC_ADDR_CRC_B3, 8'h00);
    wr(`PMC_ADDR_CRC_B0, 8'h3C);
    wait_idle();
    e = crc_calc(32, 0, `PMC_MEM_DEPTH);
    for (int i = 0; i < 4; i++)
      rd(`PMC_ADDR_CRC_B3 - 8'(i), e[31 - 8 * i -: 8]);
    rd(`PMC_ADDR_STATUS, 8'h00, 8'h01);
    $display("Test full CRC done");
    @(posedge clk_i);
    halted_i <= 1'b0;
    u_oe <= 1'b1;
    u_d <= 1'($urandom);
    repeat (6) @(negedge clk_i);
    chk(uin === u_d);
    host.set_ck(1'b0);
    repeat (8) @(negedge clk_i);
    chk(crst === 1'b1);
    host.set_ck(1'b1);
    repeat (8) @(negedge clk_i);
    chk(crst === 1'b0);
    wr(`PMC_ADDR_CRC_B1, 8'h00);
    chk(busy === 1'b0);
    $display("Test pin sharing done");
    repeat (4) @(posedge clk_i);
    report_and_stop();
  end
endmodule
